// file: hw/oaco_pkg.sv
/*
  Shared constants for the output amplifier gain/offset calibration block:
  register byte offsets, reset values, pin vector layout and the gain table.
  Assumes a 32-bit classic Wishbone slave and a single 25 MHz clock.
*/
package oaco_pkg;

  // Clock rate, for reference by any timing derived later.
  localparam int unsigned CLK_HZ = 25_000_000;

  // Register byte offsets.
  localparam logic [7:0] REG_VLOW   = 8'h00;
  localparam logic [7:0] REG_VHIGH  = 8'h04;
  localparam logic [7:0] REG_DARK   = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_CORR   = 8'h10;
  localparam logic [7:0] REG_OUT    = 8'h14;

  // Reset values of the software-written references.
  localparam logic [15:0] VLOW_RST  = 16'h0000;
  localparam logic [15:0] VHIGH_RST = 16'h0F00;
  localparam logic [15:0] DARK_RST  = 16'h0100;

  // Layout of the synchronised control pin vector.
  localparam int PIN_W        = 11;
  localparam int PIN_GAIN_LSB = 0;
  localparam int PIN_OFS_LSB  = 4;
  localparam int PIN_SEL_EXT  = 8;
  localparam int PIN_UNITY    = 9;
  localparam int PIN_CAL_F    = 10;
  localparam int PIN_CAL_S_B  = 11;

  // STATUS bit positions above the synchronised pin image.
  localparam int STAT_DARK    = 12;
  localparam int STAT_CAL_S   = 13;

  // Gain factor fraction bits, unity factor and maximum offset code.
  localparam int          GAIN_FRAC = 4;
  localparam logic [8:0]  GAIN_UNITY = 9'h010;
  localparam logic [3:0]  OFS_CODE_MAX = 4'hF;

  // Slow calibration step shift: 1/128 per pulse gives a time constant near 128 pulses.
  localparam int          SLOW_SHIFT = 7;

  // Exponential gain table, factor times 16, from 1.2 at code 0 to 16 at code 15.
  function automatic logic [8:0] gain_factor(input logic [3:0] code);
    case (code)
      4'h0: gain_factor = 9'h013;
      4'h1: gain_factor = 9'h017;
      4'h2: gain_factor = 9'h01B;
      4'h3: gain_factor = 9'h020;
      4'h4: gain_factor = 9'h026;
      4'h5: gain_factor = 9'h02E;
      4'h6: gain_factor = 9'h036;
      4'h7: gain_factor = 9'h041;
      4'h8: gain_factor = 9'h04D;
      4'h9: gain_factor = 9'h05B;
      4'hA: gain_factor = 9'h06C;
      4'hB: gain_factor = 9'h081;
      4'hC: gain_factor = 9'h099;
      4'hD: gain_factor = 9'h0B6;
      4'hE: gain_factor = 9'h0D8;
      default: gain_factor = 9'h100;
    endcase
  endfunction : gain_factor

endpackage : oaco_pkg

// file: hw/oaco_cal_if.sv
/*
  Carrier between the amplifier datapath and its offset calibration engine.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface oaco_cal_if #(
  parameter int ACC_W = 18
);
  logic                    ce;        // Clock enable, freezes the engine when low.
  logic signed [ACC_W-1:0] in_amp;    // Amplified input before offset.
  logic                    unity;     // Unity feedback pin level.
  logic                    cal_fast;  // Fast calibration pin level.
  logic                    cal_slow;  // Slow calibration pin level.
  logic signed [ACC_W-1:0] corr;      // Offset correction applied to the output.

  modport datapath (output ce, output in_amp, output unity, output cal_fast,
                    output cal_slow, input corr);
  modport engine   (input ce, input in_amp, input unity, input cal_fast,
                    input cal_slow, output corr);
endinterface : oaco_cal_if

`default_nettype wire

// file: hw/oaco_cal.sv
/*
  Offset calibration engine: fast one-shot capture and slow incremental
  convergence of the output offset correction.
  Assumes synchronised, glitch-free control levels from the datapath.
*/
`timescale 1ns/1ps
`default_nettype none

module oaco_cal #(
  parameter int ACC_W = 18
) (
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Link to the datapath.
  oaco_cal_if.engine cal
);

  logic signed [ACC_W-1:0] corr_reg;
  logic signed [ACC_W-1:0] corr_next;
  logic signed [ACC_W-1:0] cand_reg;
  logic                    fast_arm_reg;
  logic                    slow_prev_reg;
  logic signed [ACC_W-1:0] target;
  logic signed [ACC_W-1:0] slow_err;
  wire                     fast_on;
  wire                     fast_done;
  wire                     slow_fall;

  assign fast_on   = cal.cal_fast & cal.unity;
  assign fast_done = fast_arm_reg & ~cal.cal_fast;
  assign slow_fall = slow_prev_reg & ~cal.cal_slow;
  // The zero-signal input should land exactly on the DAC level.
  assign target    = -cal.in_amp;
  assign slow_err  = target - corr_reg;

  // Next correction; fast wins because it jumps straight to target.
  always_comb begin
    corr_next = corr_reg;
    if (fast_done) begin
      corr_next = cand_reg;
    end else if (slow_fall) begin
      corr_next = corr_reg + (slow_err >>> oaco_pkg::SLOW_SHIFT);
    end
  end

  // Candidate tracks the input while fast mode is closed.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      corr_reg      <= '0;
      cand_reg      <= '0;
      fast_arm_reg  <= 1'b0;
      slow_prev_reg <= 1'b0;
    end else if (cal.ce) begin
      corr_reg      <= corr_next;
      fast_arm_reg  <= fast_on;
      slow_prev_reg <= cal.cal_slow;
      if (fast_on) begin
        cand_reg <= target;
      end
    end
  end

  assign cal.corr = corr_reg;

endmodule : oaco_cal

`default_nettype wire

// file: hw/oaco_amp.sv
/*
  Output amplifier control: pin synchroniser, input selection with dark
  reference, exponential gain, linear offset DAC, calibration and a classic
  Wishbone register slave.
  Assumes the camera controller drives the control pins asynchronously and
  that pixel and external samples arrive on clk_i.

// Functional notes
// - Gain from 4-bit code, exponential steps
// - Offset linear between low and high references
// - Gain and offset codes act independently
// - Select 1 takes external input
// - Dark reference presented after row readout
// - Fast calibration settles on release
// - Slow calibration converges over ~100 pulses
// - Unity feedback overrides gain code
// - Fast adjust only with both high
*/
// Decided for this implementation: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module oaco_amp #(
  parameter int DATA_W = 12
) (
  // Clock, reset and clock enable.
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  // Classic Wishbone slave.
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [7:0]        adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  // Control pins from the camera controller.
  input  wire logic [3:0]        gain_code_i,
  input  wire logic [3:0]        offset_code_i,
  input  wire logic              sel_extin_i,
  input  wire logic              unity_feedback_i,
  input  wire logic              calib_fast_i,
  input  wire logic              calib_slow_i,
  // Samples and row sequencing from the array side.
  input  wire logic [DATA_W-1:0] pixel_i,
  input  wire logic [DATA_W-1:0] extin_i,
  input  wire logic              row_done_i,
  input  wire logic              row_start_i,
  // Amplifier output sample.
  output logic      [DATA_W-1:0] amp_out_o
);

  localparam int ACC_W = DATA_W + 6;
  localparam int PW    = oaco_pkg::PIN_W;

  // Raw pin vector and three-stage synchroniser.
  logic [PW-1:0] pin_raw;
  logic [PW-1:0] sync1_reg;
  logic [PW-1:0] sync2_reg;
  logic [PW-1:0] sync3_reg;
  logic [PW-1:0] pin_reg;
  logic [PW-1:0] pin_next;

  assign pin_raw = {calib_fast_i, unity_feedback_i, sel_extin_i, offset_code_i, gain_code_i};

  // A bit is accepted only once the second and third stages agree.
  // A bit whose stages still disagree keeps its old value, so a glitch never reads as zero.
  assign pin_next = (pin_reg & (sync2_reg ^ sync3_reg)) |
                    (sync3_reg & ~(sync2_reg ^ sync3_reg));

  // The slow pulse is synchronised apart so its falling edge is clean.
  logic [2:0] slow_sync_reg;
  logic       slow_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg     <= '0;
      sync2_reg     <= '0;
      sync3_reg     <= '0;
      pin_reg       <= '0;
      slow_sync_reg <= '0;
      slow_reg      <= 1'b0;
    end else if (ce_i) begin
      sync1_reg     <= pin_raw;
      sync2_reg     <= sync1_reg;
      sync3_reg     <= sync2_reg;
      pin_reg       <= pin_next;
      slow_sync_reg <= {slow_sync_reg[1:0], calib_slow_i};
      if (slow_sync_reg[1] == slow_sync_reg[2]) begin
        slow_reg <= slow_sync_reg[2];
      end
    end
  end

  // Decoded control levels.
  wire [3:0] gain_code   = pin_reg[oaco_pkg::PIN_GAIN_LSB +: 4];
  wire [3:0] offset_code = pin_reg[oaco_pkg::PIN_OFS_LSB +: 4];
  wire       sel_ext     = pin_reg[oaco_pkg::PIN_SEL_EXT];
  wire       unity       = pin_reg[oaco_pkg::PIN_UNITY];
  wire       cal_fast    = pin_reg[oaco_pkg::PIN_CAL_F];

  // Software references and the dark-reference flag.
  logic [15:0] vlow_reg;
  logic [15:0] vhigh_reg;
  logic [15:0] dark_reg;
  logic        dark_on_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dark_on_reg <= 1'b0;
    end else if (ce_i) begin
      if (row_done_i) begin
        dark_on_reg <= 1'b1;   // A new row done wins over a start in the same cycle.
      end else if (row_start_i) begin
        dark_on_reg <= 1'b0;
      end
    end
  end

  // Input multiplexer: external pin, else array or its dark reference.
  logic [DATA_W-1:0] amp_in;
  assign amp_in = sel_ext     ? extin_i :
                  dark_on_reg ? dark_reg[DATA_W-1:0] : pixel_i;

  // Gain stage; unity feedback forces a factor of one.
  logic [8:0]              gain_fac;
  logic [DATA_W+8:0]       prod;
  logic signed [ACC_W-1:0] in_amp;
  assign gain_fac = unity ? oaco_pkg::GAIN_UNITY : oaco_pkg::gain_factor(gain_code);
  assign prod     = amp_in * gain_fac;
  assign in_amp   = signed'({1'b0, prod[DATA_W+8:oaco_pkg::GAIN_FRAC]});

  // Offset DAC, linear between the two references, gain-independent.
  logic signed [17:0]      dac_span;
  logic signed [22:0]      dac_prod;
  logic signed [ACC_W-1:0] dac_lvl;
  assign dac_span = signed'({2'b00, vhigh_reg}) - signed'({2'b00, vlow_reg});
  assign dac_prod = dac_span * signed'({1'b0, offset_code});
  assign dac_lvl  = ACC_W'(signed'({2'b00, vlow_reg}) +
                    ACC_W'(dac_prod / signed'({1'b0, oaco_pkg::OFS_CODE_MAX})));

  // Calibration engine.
  oaco_cal_if #(.ACC_W(ACC_W)) cal_bus ();

  assign cal_bus.ce       = ce_i;
  assign cal_bus.in_amp   = in_amp;
  assign cal_bus.unity    = unity;
  assign cal_bus.cal_fast = cal_fast;
  assign cal_bus.cal_slow = slow_reg;

  oaco_cal #(.ACC_W(ACC_W)) u_cal (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .cal   (cal_bus.engine)
  );

  // Output sum, saturated into the sample range.
  logic signed [ACC_W-1:0] out_sum;
  logic        [DATA_W-1:0] out_sat;
  assign out_sum = in_amp + dac_lvl + cal_bus.corr;
  assign out_sat = (out_sum < 0) ? '0 :
                   (out_sum > ACC_W'({DATA_W{1'b1}})) ? {DATA_W{1'b1}} :
                   out_sum[DATA_W-1:0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      amp_out_o <= '0;
    end else if (ce_i) begin
      amp_out_o <= out_sat;
    end
  end

  // Byte-lane merge for the 16-bit wide references.
  function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                             input logic [31:0] wdat,
                                             input logic [3:0]  sel);
    lane_merge = old;
    if (sel[0]) begin
      lane_merge[7:0] = wdat[7:0];
    end
    if (sel[1]) begin
      lane_merge[15:8] = wdat[15:8];
    end
  endfunction : lane_merge

  // Bus decode; unmapped addresses are acknowledged and read as zero.
  wire req     = cyc_i & stb_i & ~ack_o;
  wire wr      = req & we_i;
  wire hit_lo  = (adr_i == oaco_pkg::REG_VLOW);
  wire hit_hi  = (adr_i == oaco_pkg::REG_VHIGH);
  wire hit_dk  = (adr_i == oaco_pkg::REG_DARK);
  wire [31:0] status_word = {18'h0_0000, slow_reg, dark_on_reg, 1'b0, pin_reg};
  wire [31:0] corr_word   = 32'(signed'(cal_bus.corr));
  logic [31:0] rd_word;

  always_comb begin
    if (hit_lo) begin
      rd_word = {16'h0000, vlow_reg};
    end else if (hit_hi) begin
      rd_word = {16'h0000, vhigh_reg};
    end else if (hit_dk) begin
      rd_word = {16'h0000, dark_reg};
    end else if (adr_i == oaco_pkg::REG_STATUS) begin
      rd_word = status_word;
    end else if (adr_i == oaco_pkg::REG_CORR) begin
      rd_word = corr_word;
    end else if (adr_i == oaco_pkg::REG_OUT) begin
      rd_word = 32'(amp_out_o);
    end else begin
      rd_word = 32'h0000_0000;
    end
  end

  // One-cycle ack; the bus freezes with the rest while the clock enable is low.
  // A master must therefore wait for ack rather than count cycles.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o     <= 1'b0;
      dat_o     <= 32'h0000_0000;
      vlow_reg  <= oaco_pkg::VLOW_RST;
      vhigh_reg <= oaco_pkg::VHIGH_RST;
      dark_reg  <= oaco_pkg::DARK_RST;
    end else if (ce_i) begin
      ack_o <= req;
      dat_o <= req ? rd_word : 32'h0000_0000;
      if (wr && hit_lo) begin
        vlow_reg <= lane_merge(vlow_reg, dat_i, sel_i);
      end
      if (wr && hit_hi) begin
        vhigh_reg <= lane_merge(vhigh_reg, dat_i, sel_i);
      end
      if (wr && hit_dk) begin
        dark_reg <= lane_merge(dark_reg, dat_i, sel_i);
      end
    end
  end

endmodule : oaco_amp

`default_nettype wire

// file: test/oaco_amp_monitor.sv
/*
  Checker for the amplifier control block, bound to its top module.
  Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none

module oaco_amp_monitor #(
  parameter int DATA_W = 12
) (
  // Clock, reset and enable.
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              ce_i,
  // Bus.
  input wire logic              cyc_i,
  input wire logic              stb_i,
  input wire logic [31:0]       dat_o,
  input wire logic              ack_o,
  // Pins and samples.
  input wire logic [3:0]        gain_code_i,
  input wire logic [3:0]        offset_code_i,
  input wire logic              sel_extin_i,
  input wire logic              unity_feedback_i,
  input wire logic              calib_fast_i,
  input wire logic              calib_slow_i,
  input wire logic [DATA_W-1:0] pixel_i,
  input wire logic [DATA_W-1:0] extin_i,
  input wire logic              row_done_i,
  input wire logic              row_start_i,
  input wire logic [DATA_W-1:0] amp_out_o
);
  // Gain under unity feedback and fast calibration without it are masked, as neither may act.
  wire  [DATA_W+14:0] pins_v = {cyc_i, offset_code_i, sel_extin_i, unity_feedback_i,
                                calib_slow_i, row_done_i, row_start_i, extin_i,
                                calib_fast_i & unity_feedback_i,
                                gain_code_i & {4{~unity_feedback_i}}};
  logic [DATA_W+14:0] pins_q;
  logic [DATA_W-1:0]  pix_q;
  logic [3:0]         cnt_q;
  logic [3:0]         pcnt_q;
  logic               dark_q;
  wire                moved = (pins_v != pins_q) || !ce_i;

  // Quiet counters saturate, so a long idle spell cannot wrap back to zero.
  always_ff @(posedge clk_i) begin
    pins_q <= pins_v;
    pix_q  <= pixel_i;
    cnt_q  <= (rst_i || moved) ? 4'h0 : cnt_q + {3'h0, cnt_q != 4'hF};
    pcnt_q <= (rst_i || moved || pixel_i != pix_q) ? 4'h0 : pcnt_q + {3'h0, pcnt_q != 4'hF};
  end

  // Dark reference window, from row end to row start.
  always_ff @(posedge clk_i) begin
    if (rst_i || row_start_i) dark_q <= 1'b0;
    if (row_done_i) dark_q <= 1'b1;
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_ACK_ONE_CYCLE: assert property (ack_o && ce_i |=> !ack_o)
    else $error("ack held longer than one cycle");
  AST_ACK_CAUSE: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i && ce_i))
    else $error("ack without a request");
  AST_ACK_ANSWER: assert property (cyc_i && stb_i && ce_i && !ack_o |=> ack_o)
    else $error("request not answered next cycle");
  AST_DAT_IDLE: assert property (!ack_o |-> dat_o == 32'h0000_0000)
    else $error("read data outside ack cycle");
  AST_FREEZE: assert property (!ce_i |=> $stable(amp_out_o) && $stable(ack_o))
    else $error("state moved while enable low");
  AST_EXT_SELECT: assert property (cnt_q >= 4'h7 && !moved && sel_extin_i |=> $stable(amp_out_o))
    else $error("output follows pixel while external selected");
  AST_DARK_HOLD: assert property (cnt_q >= 4'h7 && !moved && dark_q |=> $stable(amp_out_o))
    else $error("output follows pixel during dark reference");
  AST_QUIET_OUT: assert property (pcnt_q >= 4'h7 && !moved && pixel_i == pix_q
                                  |-> ##1 $stable(amp_out_o)[*2])
    else $error("output moved with no cause");

  // Main scenarios reached.
  COV_DARK: cover property (dark_q && cnt_q >= 4'h7);
  COV_FAST: cover property (calib_fast_i && unity_feedback_i);
  COV_SLOW: cover property ($fell(calib_slow_i));
endmodule : oaco_amp_monitor

bind oaco_amp oaco_amp_monitor #(.DATA_W(DATA_W)) i_oaco_amp_monitor (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .dat_o(dat_o), .ack_o(ack_o), .gain_code_i(gain_code_i), .offset_code_i(offset_code_i),
  .sel_extin_i(sel_extin_i), .unity_feedback_i(unity_feedback_i),
  .calib_fast_i(calib_fast_i), .calib_slow_i(calib_slow_i), .pixel_i(pixel_i),
  .extin_i(extin_i), .row_done_i(row_done_i), .row_start_i(row_start_i),
  .amp_out_o(amp_out_o));

`default_nettype wire

// file: test/oaco_ctrl_model.sv
/*
  Model of the camera timing controller driving the amplifier control pins.
  Assumes the caller invokes one task at a time; pins move just after clk_i rises.
*/
`timescale 1ns/1ps
`default_nettype none

module oaco_ctrl_model (
  // Clock.
  input  wire logic       clk_i,
  // Control pins.
  output var  logic [3:0] gain_code_o,
  output var  logic [3:0] offset_code_o,
  output var  logic       sel_extin_o,
  output var  logic       unity_o,
  output var  logic       cal_fast_o,
  output var  logic       cal_slow_o,
  output var  logic       row_done_o,
  output var  logic       row_start_o
);
  // All pins idle until the first task.
  initial begin
    {gain_code_o, offset_code_o, sel_extin_o, unity_o} = 10'h000;
    {cal_fast_o, cal_slow_o, row_done_o, row_start_o} = 4'h0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  task automatic set_pins(input logic [3:0] g, input logic [3:0] o, input logic s,
                          input logic u);
    @(posedge clk_i);
    gain_code_o   <= g;
    offset_code_o <= o;
    sel_extin_o   <= s;
    unity_o       <= u;
    tick(8);
  endtask : set_pins

  // one fast calibration with input and code held
  task automatic fast_cal();
    @(posedge clk_i);
    cal_fast_o <= 1'b1;
    tick(8);
    cal_fast_o <= 1'b0;
    tick(8);
  endtask : fast_cal

  // one slow pulse falling on a steady input
  task automatic slow_pulse();
    @(posedge clk_i);
    cal_slow_o <= 1'b1;
    tick(3);
    cal_slow_o <= 1'b0;
    tick(8);
  endtask : slow_pulse

  // Row end or row start, a one-cycle pulse.
  task automatic row_edge(input logic done);
    @(posedge clk_i);
    row_done_o  <= done;
    row_start_o <= !done;
    @(posedge clk_i);
    row_done_o  <= 1'b0;
    row_start_o <= 1'b0;
    tick(8);
  endtask : row_edge
endmodule : oaco_ctrl_model

`default_nettype wire

// file: test/tb_top.sv
/*
  Self-checking bench for the amplifier control block.
  Assumes the controller model drives the pins; the bench drives bus and samples.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  typedef struct packed {
    logic [3:0]  g;
    logic [3:0]  o;
    logic        s;
    logic        u;
    logic [11:0] e;
  } oaco_row_t;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        ce_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [11:0] pixel_i = 12'h050;
  logic [11:0] extin_i = 12'h100;
  logic [31:0] dat_o;
  logic [31:0] rd;
  logic        ack_o;
  logic [3:0]  gain_code;
  logic [3:0]  offset_code;
  logic [11:0] amp_out_o;
  logic        sel_ext, unity, cal_f, cal_s, row_done, row_start;
  int          errors = 0;
  int          checked = 0;
  int          cycles = 0;
  // Gain, offset, select, unity, then the output for extin 0x100 and pixel 0x050.
  oaco_row_t   rows [7] = '{'{4'h0, 4'h0, 1'b1, 1'b0, 12'h130}, '{4'h4, 4'h0, 1'b1, 1'b0, 12'h260},
                           '{4'h4, 4'h3, 1'b1, 1'b0, 12'h560}, '{4'hF, 4'h0, 1'b1, 1'b0, 12'hFFF},
                           '{4'h8, 4'h1, 1'b1, 1'b0, 12'h5D0}, '{4'hF, 4'h3, 1'b1, 1'b1, 12'h400},
                           '{4'h4, 4'h3, 1'b0, 1'b0, 12'h3BE}};

  oaco_amp #(.DATA_W(12)) i_oaco_amp (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(4'h3), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .gain_code_i(gain_code), .offset_code_i(offset_code), .sel_extin_i(sel_ext),
    .unity_feedback_i(unity), .calib_fast_i(cal_f), .calib_slow_i(cal_s),
    .pixel_i(pixel_i), .extin_i(extin_i), .row_done_i(row_done), .row_start_i(row_start),
    .amp_out_o(amp_out_o));

  oaco_ctrl_model i_oaco_ctrl_model (
    .clk_i(clk_i), .gain_code_o(gain_code), .offset_code_o(offset_code),
    .sel_extin_o(sel_ext), .unity_o(unity), .cal_fast_o(cal_f), .cal_slow_o(cal_s),
    .row_done_o(row_done), .row_start_o(row_start));

  // Clock at 25 MHz.
  initial begin
    forever #20 clk_i = ~clk_i;
  end

  task automatic give_verdict();
    if (errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  // The whole run needs well under a thousand cycles; a hang ends here.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      give_verdict();
    end
  end

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // One classic cycle, held until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i} <= {2'b11, w};
    adr_i <= a;
    dat_i <= d;
    // Only the bench timeout ends a wait that never sees ack.
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    rd = dat_o;
    {cyc_i, stb_i} <= 2'b00;
    @(posedge clk_i);
  endtask : wb

  task automatic expect_out(input string name, input logic [11:0] e);
    check(name, 32'(e), 32'(amp_out_o));
  endtask : expect_out

  initial begin
    repeat (2) @(posedge clk_i);
    check("ack in reset", 32'h0000_0000, 32'(ack_o));
    rst_i <= 1'b0;
    wb(1'b0, 8'h04, 32'h0000_0000);
    check("vhigh reset", 32'h0000_0F00, rd);
    wb(1'b0, 8'h1C, 32'h0000_0000);
    check("unmapped read", 32'h0000_0000, rd);
    foreach (rows[i]) begin
      i_oaco_ctrl_model.set_pins(rows[i].g, rows[i].o, rows[i].s, rows[i].u);
      expect_out("table out", rows[i].e);
    end
    wb(1'b0, 8'h0C, 32'h0000_0000);
    check("status", 32'h0000_0034, rd);
    wb(1'b1, 8'h08, 32'h0000_0300);
    i_oaco_ctrl_model.set_pins(4'h4, 4'h0, 1'b0, 1'b0);
    i_oaco_ctrl_model.row_edge(1'b1);
    pixel_i <= 12'h0A0;
    repeat (8) @(posedge clk_i);
    expect_out("dark out", 12'h720);
    i_oaco_ctrl_model.row_edge(1'b0);
    expect_out("pixel after row start", 12'h17C);
    i_oaco_ctrl_model.set_pins(4'h4, 4'h0, 1'b1, 1'b0);
    i_oaco_ctrl_model.fast_cal();
    expect_out("fast without unity", 12'h260);
    i_oaco_ctrl_model.set_pins(4'h4, 4'h2, 1'b1, 1'b1);
    expect_out("unity before cal", 12'h300);
    i_oaco_ctrl_model.fast_cal();
    expect_out("fast cal", 12'h200);
    extin_i <= 12'h180;
    repeat (8) @(posedge clk_i);
    expect_out("input moved", 12'h280);
    i_oaco_ctrl_model.slow_pulse();
    expect_out("slow step", 12'h27F);
    ce_i <= 1'b0;
    extin_i <= 12'h100;
    repeat (8) @(posedge clk_i);
    expect_out("frozen", 12'h27F);
    ce_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    expect_out("thawed", 12'h1FF);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h08, 32'h0000_0000);
    check("dark after reset", 32'h0000_0100, rd);
    give_verdict();
  end
endmodule : tb_top

`default_nettype wire
